// ### rtl/cfg_regs_pkg.sv
`default_nettype none
package cfg_regs_pkg;

    // ==========================================================
    // register indices
    localparam logic [7:0] IDX_AUX_LOW = 8'h08;
    localparam logic [7:0] IDX_AUX_HIGH = 8'h09;
    localparam logic [7:0] IDX_ECP_IR = 8'h0A;
    localparam logic [7:0] IDX_DRIVE_RATE = 8'h0B;
    localparam logic [7:0] IDX_SERIAL_MODE = 8'h0C;
    localparam logic [7:0] IDX_DEVICE_ID = 8'h0D;

    // ==========================================================
    // reset values and writable masks
    localparam logic [7:0] RST_AUX_LOW = 8'h00;
    localparam logic [7:0] RST_AUX_HIGH = 8'h00;
    localparam logic [7:0] RST_ECP_IR = 8'h00;
    localparam logic [7:0] RST_DRIVE_RATE = 8'h00;
    localparam logic [7:0] RST_SERIAL_MODE = 8'h02;
    localparam logic [7:0] MASK_AUX_LOW = 8'hF0;
    localparam logic [7:0] MASK_AUX_HIGH = 8'hCF;
    localparam logic [7:0] MASK_ECP_IR = 8'hCF;
    // arbitrary neutral identifier value
    localparam logic [7:0] DEVICE_ID_VALUE = 8'h5A;

    // ==========================================================
    // field positions
    localparam int DEC_MODE_LSB = 6;
    localparam int IR_MUX_LSB = 6;
    localparam int UART2_MODE_LSB = 3;
    localparam int RX_POL_BIT = 0;
    localparam int TX_POL_BIT = 1;
    localparam int DUPLEX_BIT = 2;
    localparam int UART1_HS_BIT = 6;
    localparam int UART2_HS_BIT = 7;

    // ==========================================================
    // field encodings
    localparam logic [1:0] DEC_OFF = 2'h0;
    localparam logic [1:0] DEC_ONE_BYTE = 2'h1;
    localparam logic [1:0] DEC_EIGHT_BYTE = 2'h2;
    localparam logic [1:0] DEC_SIXTEEN_BYTE = 2'h3;
    localparam logic [1:0] IR_ROUTE_PRIMARY = 2'h0;
    localparam logic [1:0] IR_ROUTE_SECONDARY = 2'h1;
    localparam logic [1:0] IR_ROUTE_OFF = 2'h3;
    localparam logic [3:0] ADDR_HIGH_ZERO = 4'h0;

endpackage
`default_nettype wire

// ### rtl/aux_block_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module aux_block_decoder (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] base_i,
    input wire logic [1:0] mode_i,
    output logic aux_block_select_n_o
);
    logic hit;

    // ==========================================================
    // block match
    always_comb begin
        hit = 1'b0;
        if (io_addr_i[15:12] == cfg_regs_pkg::ADDR_HIGH_ZERO && io_addr_i[11:4] == base_i) begin // [RQ5]
            unique case (mode_i) // [RQ6]
                cfg_regs_pkg::DEC_OFF: hit = 1'b0;
                cfg_regs_pkg::DEC_ONE_BYTE: hit = (io_addr_i[3:0] == 4'h0);
                cfg_regs_pkg::DEC_EIGHT_BYTE: hit = ~io_addr_i[3];
                cfg_regs_pkg::DEC_SIXTEEN_BYTE: hit = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aux_block_select_n_o <= 1'b1;
        end else begin
            aux_block_select_n_o <= ~hit; // [RQ5]
        end
    end
endmodule // aux_block_decoder
`default_nettype wire

// ### rtl/config_regs_addr_decode_uart_ir.sv
// Functional notes
// (RQ1) access only in config state at matching index
// (RQ2) low decoder holds address 7:4, resets zero
// (RQ3) reserved bits ignore writes, read zero
// (RQ4) high decoder: address 11:8, mode 7:6
// (RQ5) select only on match with top nibble zero
// (RQ6) mode: off, one, eight, sixteen bytes
// (RQ7) ecp threshold in bits 3:0, resets zero
// (RQ8) ir mux bits 7:6 reset by reset
// (RQ9) ir route primary, secondary, or both off
// (RQ10) two rate select bits per drive, reset zero
// (RQ11) serial mode resets to 02h
// (RQ12) bit0 second uart receive polarity
// (RQ13) bit1 second uart transmit polarity, default low
// (RQ14) bit2 second uart half duplex
// (RQ15) bits 5:3 second uart mode
// (RQ16) bits 6,7 high speed per uart
// (RQ17) identifier register fixed, read only
// (RQ18) identifier writes accepted and discarded
`timescale 1ns/1ps
`default_nettype none
module config_regs_addr_decode_uart_ir (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic config_state_i,
    input wire logic [7:0] config_index_register_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_wdata_i,
    input wire logic [15:0] io_addr_i,
    input wire logic ir_transmit_i,
    output logic [7:0] cfg_rdata_o,
    output logic aux_block_select_n_o,
    output logic [3:0] ecp_threshold_o,
    output logic [7:0] drive_rate_sel_o,
    output logic uart2_rx_active_low_o,
    output logic uart2_tx_active_low_o,
    output logic uart2_half_duplex_o,
    output logic [2:0] uart2_mode_o,
    output logic uart1_high_speed_o,
    output logic uart2_high_speed_o,
    output logic ir_transmit_primary_o,
    output logic ir_transmit_primary_oe_o,
    output logic ir_transmit_secondary_o,
    output logic ir_transmit_secondary_oe_o,
    output logic ir_receive_select_secondary_o
);
    // ==========================================================
    // stored registers
    logic [7:0] aux_low_r;
    logic [7:0] aux_high_r;
    logic [7:0] ecp_ir_r;
    logic [7:0] drive_rate_r;
    logic [7:0] serial_mode_r;

    // ==========================================================
    // strobes, read path and routing
    logic wr_aux_low;
    logic wr_aux_high;
    logic wr_ecp_ir;
    logic wr_drive_rate;
    logic wr_serial_mode;
    logic rd_valid;
    logic [7:0] rd_value;
    logic [7:0] decoder_base;
    logic [1:0] decoder_mode;
    logic [1:0] ir_route;
    logic route_primary;
    logic route_secondary;

    // ==========================================================
    // access qualification
    // index and state are levels kept by the entry logic outside
    function automatic logic hit_idx(input logic [7:0] idx);
        hit_idx = config_state_i && (config_index_register_i == idx); // [RQ1]
    endfunction

    // ==========================================================
    // route code compare
    function automatic logic route_is(input logic [1:0] route, input logic [1:0] code);
        route_is = (route == code);
    endfunction

    // ==========================================================
    // write strobes
    // the identifier index raises no strobe, so its writes drop [RQ18]
    always_comb begin
        wr_aux_low = cfg_wr_i && hit_idx(cfg_regs_pkg::IDX_AUX_LOW); // [RQ1]
        wr_aux_high = cfg_wr_i && hit_idx(cfg_regs_pkg::IDX_AUX_HIGH); // [RQ1]
        wr_ecp_ir = cfg_wr_i && hit_idx(cfg_regs_pkg::IDX_ECP_IR); // [RQ1]
        wr_drive_rate = cfg_wr_i && hit_idx(cfg_regs_pkg::IDX_DRIVE_RATE); // [RQ1]
        wr_serial_mode = cfg_wr_i && hit_idx(cfg_regs_pkg::IDX_SERIAL_MODE); // [RQ1]
    end

    // ==========================================================
    // lower decoder address; low nibble masked, never stored
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aux_low_r <= cfg_regs_pkg::RST_AUX_LOW; // [RQ2]
        end else if (wr_aux_low) begin
            aux_low_r <= cfg_wdata_i & cfg_regs_pkg::MASK_AUX_LOW; // [RQ2] [RQ3]
        end
    end

    // ==========================================================
    // upper decoder address and decoder mode
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aux_high_r <= cfg_regs_pkg::RST_AUX_HIGH; // [RQ4]
        end else if (wr_aux_high) begin
            aux_high_r <= cfg_wdata_i & cfg_regs_pkg::MASK_AUX_HIGH; // [RQ3] [RQ4]
        end
    end

    // ==========================================================
    // threshold and infrared mux; mux back to default on reset
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ecp_ir_r <= cfg_regs_pkg::RST_ECP_IR; // [RQ7] [RQ8]
        end else if (wr_ecp_ir) begin
            ecp_ir_r <= cfg_wdata_i & cfg_regs_pkg::MASK_ECP_IR; // [RQ3] [RQ7]
        end
    end

    // ==========================================================
    // drive rate table selectors
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            drive_rate_r <= cfg_regs_pkg::RST_DRIVE_RATE; // [RQ10]
        end else if (wr_drive_rate) begin
            drive_rate_r <= cfg_wdata_i; // [RQ10]
        end
    end

    // ==========================================================
    // serial mode; reserved mode codes kept as written
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            serial_mode_r <= cfg_regs_pkg::RST_SERIAL_MODE; // [RQ11]
        end else if (wr_serial_mode) begin
            serial_mode_r <= cfg_wdata_i; // [RQ12] [RQ13] [RQ14] [RQ15] [RQ16]
        end
    end

    // ==========================================================
    // read mux
    // unknown indices read zero rather than stale data
    always_comb begin
        rd_valid = cfg_rd_i && config_state_i; // [RQ1]
        unique case (config_index_register_i)
            cfg_regs_pkg::IDX_AUX_LOW: rd_value = aux_low_r; // [RQ2] [RQ3]
            cfg_regs_pkg::IDX_AUX_HIGH: rd_value = aux_high_r; // [RQ4]
            cfg_regs_pkg::IDX_ECP_IR: rd_value = ecp_ir_r; // [RQ7]
            cfg_regs_pkg::IDX_DRIVE_RATE: rd_value = drive_rate_r; // [RQ10]
            cfg_regs_pkg::IDX_SERIAL_MODE: rd_value = serial_mode_r; // [RQ11]
            cfg_regs_pkg::IDX_DEVICE_ID: rd_value = cfg_regs_pkg::DEVICE_ID_VALUE; // [RQ17]
            default: rd_value = 8'h00;
        endcase
    end

    // ==========================================================
    // read data, one cycle after the read, then zero
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cfg_rdata_o <= 8'h00;
        end else if (rd_valid) begin
            cfg_rdata_o <= rd_value; // [RQ1]
        end else begin
            cfg_rdata_o <= 8'h00;
        end
    end

    // ==========================================================
    // auxiliary decoder
    // base spans two registers, joined here
    always_comb begin
        decoder_base = {aux_high_r[3:0], aux_low_r[7:4]}; // [RQ5]
        decoder_mode = aux_high_r[cfg_regs_pkg::DEC_MODE_LSB +: 2]; // [RQ6]
    end

    aux_block_decoder aux_block_decoder_inst (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .io_addr_i(io_addr_i),
        .base_i(decoder_base), // [RQ5]
        .mode_i(decoder_mode), // [RQ6]
        .aux_block_select_n_o(aux_block_select_n_o)
    );

    // ==========================================================
    // parallel port threshold
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ecp_threshold_o <= 4'h0;
        end else begin
            ecp_threshold_o <= ecp_ir_r[3:0]; // [RQ7]
        end
    end

    // ==========================================================
    // drive rate selectors out
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            drive_rate_sel_o <= 8'h00;
        end else begin
            drive_rate_sel_o <= drive_rate_r; // [RQ10]
        end
    end

    // ==========================================================
    // second uart receive polarity
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uart2_rx_active_low_o <= 1'b0;
        end else begin
            uart2_rx_active_low_o <= serial_mode_r[cfg_regs_pkg::RX_POL_BIT]; // [RQ12]
        end
    end

    // ==========================================================
    // second uart transmit polarity, low by default
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uart2_tx_active_low_o <= 1'b1;
        end else begin
            uart2_tx_active_low_o <= serial_mode_r[cfg_regs_pkg::TX_POL_BIT]; // [RQ13]
        end
    end

    // ==========================================================
    // second uart duplex
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uart2_half_duplex_o <= 1'b0;
        end else begin
            uart2_half_duplex_o <= serial_mode_r[cfg_regs_pkg::DUPLEX_BIT]; // [RQ14]
        end
    end

    // ==========================================================
    // second uart mode; reserved codes passed on unchanged
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uart2_mode_o <= 3'h0;
        end else begin
            uart2_mode_o <= serial_mode_r[cfg_regs_pkg::UART2_MODE_LSB +: 3]; // [RQ15]
        end
    end

    // ==========================================================
    // first uart speed
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uart1_high_speed_o <= 1'b0;
        end else begin
            uart1_high_speed_o <= serial_mode_r[cfg_regs_pkg::UART1_HS_BIT]; // [RQ16]
        end
    end

    // ==========================================================
    // second uart speed
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            uart2_high_speed_o <= 1'b0;
        end else begin
            uart2_high_speed_o <= serial_mode_r[cfg_regs_pkg::UART2_HS_BIT]; // [RQ16]
        end
    end

    // ==========================================================
    // infrared pin route
    // reserved code 10 leaves both pins undriven, like 11
    always_comb begin
        ir_route = ecp_ir_r[cfg_regs_pkg::IR_MUX_LSB +: 2]; // [RQ8]
        route_primary = route_is(ir_route, cfg_regs_pkg::IR_ROUTE_PRIMARY); // [RQ9]
        route_secondary = route_is(ir_route, cfg_regs_pkg::IR_ROUTE_SECONDARY); // [RQ9]
    end

    // ==========================================================
    // primary infrared transmit pin
    // data follows the uart always; only the enable follows the route
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ir_transmit_primary_o <= 1'b0;
            ir_transmit_primary_oe_o <= 1'b1;
        end else begin
            ir_transmit_primary_o <= ir_transmit_i;
            ir_transmit_primary_oe_o <= route_primary; // [RQ9]
        end
    end

    // ==========================================================
    // secondary infrared transmit pin
    // never enabled together with the primary pin
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ir_transmit_secondary_o <= 1'b0;
            ir_transmit_secondary_oe_o <= 1'b0;
        end else begin
            ir_transmit_secondary_o <= ir_transmit_i;
            ir_transmit_secondary_oe_o <= route_secondary; // [RQ9]
        end
    end

    // ==========================================================
    // infrared receive pin choice
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ir_receive_select_secondary_o <= 1'b0;
        end else begin
            ir_receive_select_secondary_o <= route_secondary; // [RQ9]
        end
    end
endmodule // config_regs_addr_decode_uart_ir
`default_nettype wire

// ### test/config_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module config_regs_asserts (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic config_state_i,
    input wire logic [7:0] config_index_register_i,
    input wire logic cfg_rd_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] cfg_rdata_o,
    input wire logic aux_block_select_n_o,
    input wire logic ir_transmit_primary_oe_o,
    input wire logic ir_transmit_secondary_oe_o
);
    // ==========================================================
    // port relations
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence rd_at(logic [7:0] ix);
        cfg_rd_i && config_state_i && config_index_register_i == ix;
    endsequence
    a_rd_refused: assert property (cfg_rd_i && !config_state_i |=> cfg_rdata_o == 8'h00)
        else $error("read outside config state returned data");
    a_rd_idle: assert property (!cfg_rd_i |=> cfg_rdata_o == 8'h00)
        else $error("read data seen without a read");
    a_id_fixed: assert property (rd_at(8'h0d) |=> cfg_rdata_o == cfg_regs_pkg::DEVICE_ID_VALUE)
        else $error("identifier read wrong");
    a_low_rsvd: assert property (rd_at(8'h08) |=> cfg_rdata_o[3:0] == 4'h0)
        else $error("low decoder reserved bits not zero");
    a_high_rsvd: assert property (rd_at(8'h09) |=> cfg_rdata_o[5:4] == 2'h0)
        else $error("high decoder reserved bits not zero");
    a_ecp_rsvd: assert property (rd_at(8'h0a) |=> cfg_rdata_o[5:4] == 2'h0)
        else $error("threshold reserved bits not zero");
    a_sel_top: assert property (io_addr_i[15:12] != 4'h0 |=> aux_block_select_n_o)
        else $error("select with upper address nibble set");
    a_tx_oe_excl: assert property (!(ir_transmit_primary_oe_o && ir_transmit_secondary_oe_o))
        else $error("both infrared transmit pins driven");
endmodule // config_regs_asserts
bind config_regs_addr_decode_uart_ir config_regs_asserts asserts_inst (.mclk_i, .rst_i,
    .config_state_i, .config_index_register_i, .cfg_rd_i, .io_addr_i, .cfg_rdata_o,
    .aux_block_select_n_o, .ir_transmit_primary_oe_o, .ir_transmit_secondary_oe_o);
`default_nettype wire

// ### test/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic mclk_i,
    input wire logic [7:0] cfg_rdata_i,
    output logic config_state_o,
    output logic [7:0] index_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    // ==========================================================
    // one strobe per cycle, index held as a level
    logic in_cfg = 1'b1;
    assign config_state_o = in_cfg;
    initial begin
        index_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
        @(posedge mclk_i);
        #1 index_o = i;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge mclk_i);
        #1 wr_o = 1'b0;
        wdata_o = ~d; // released data never echoes the last byte
    endtask
    task automatic rd_reg(input logic [7:0] i, output logic [7:0] d);
        @(posedge mclk_i);
        #1 index_o = i;
        rd_o = 1'b1;
        @(posedge mclk_i);
        #1 rd_o = 1'b0;
        d = cfg_rdata_i; // valid only in this cycle
    endtask
endmodule // host_bus_model
`default_nettype wire

// ### test/config_regs_addr_decode_uart_ir_tb.sv
`timescale 1ns/1ps
`default_nettype none
module config_regs_addr_decode_uart_ir_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic ir_tx = 1'b0;
    logic st, wr, rd, sel_n, rxp, txp, hd, hs1, hs2, pt, poe, sto, soe, rsel;
    logic [7:0] ix, wd, rdata, drt, d;
    logic [3:0] ecp;
    logic [2:0] md;
    int n_fail = 0;
    int checks_done = 0;
    wire logic [7:0] sview = {hs2, hs1, md, hd, txp, rxp};
    wire logic [7:0] irv = {5'h00, poe, soe, rsel};
    always #2 mclk_i = ~mclk_i;
    host_bus_model host_bus_model_inst (.mclk_i(mclk_i), .cfg_rdata_i(rdata), .config_state_o(st),
        .index_o(ix), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
    config_regs_addr_decode_uart_ir config_regs_addr_decode_uart_ir_inst (.mclk_i(mclk_i),
        .rst_i(rst_i), .config_state_i(st), .config_index_register_i(ix), .cfg_wr_i(wr),
        .cfg_rd_i(rd), .cfg_wdata_i(wd), .io_addr_i(io_addr), .ir_transmit_i(ir_tx),
        .cfg_rdata_o(rdata), .aux_block_select_n_o(sel_n), .ecp_threshold_o(ecp),
        .drive_rate_sel_o(drt), .uart2_rx_active_low_o(rxp), .uart2_tx_active_low_o(txp),
        .uart2_half_duplex_o(hd), .uart2_mode_o(md), .uart1_high_speed_o(hs1),
        .uart2_high_speed_o(hs2), .ir_transmit_primary_o(pt), .ir_transmit_primary_oe_o(poe),
        .ir_transmit_secondary_o(sto), .ir_transmit_secondary_oe_o(soe),
        .ir_receive_select_secondary_o(rsel));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] i, input logic [7:0] exp);
        host_bus_model_inst.rd_reg(i, d);
        chk("register", exp, d);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, cfg_regs_pkg::DEVICE_ID_VALUE};
        for (int i = 0; i < 6; i++) rchk(8'h08 + 8'(i), ex[i]);
        chk("serial out", 8'h02, sview);
        chk("ir route", 8'h04, irv);
        $display("reset values done");
    endtask
    task automatic t_write();
        logic [7:0] ex [5] = '{8'hf0, 8'hcf, 8'hcf, 8'hff, 8'hff};
        for (int i = 0; i < 5; i++) host_bus_model_inst.wr_reg(8'h08 + 8'(i), 8'hff);
        for (int i = 0; i < 5; i++) rchk(8'h08 + 8'(i), ex[i]);
        chk("fields", 8'hff, sview);
        chk("rate and threshold", 8'hff, drt & {4'hf, ecp});
        chk("ir off", 8'h00, irv);
        $display("write masks done");
    endtask
    task automatic t_refuse();
        host_bus_model_inst.in_cfg = 1'b0;
        host_bus_model_inst.wr_reg(8'h0c, 8'h00);
        rchk(8'h0c, 8'h00);
        host_bus_model_inst.in_cfg = 1'b1;
        host_bus_model_inst.wr_reg(8'h0d, 8'h00);
        host_bus_model_inst.wr_reg(8'h0e, 8'h00);
        rchk(8'h0c, 8'hff);
        rchk(8'h0d, cfg_regs_pkg::DEVICE_ID_VALUE);
        $display("refused access done");
    endtask
    task automatic t_route();
        host_bus_model_inst.wr_reg(8'h0a, 8'h40);
        rchk(8'h0a, 8'h40);
        chk("ir secondary", 8'h03, irv);
        ir_tx = 1'b1;
        @(posedge mclk_i);
        #1 chk("ir data", 8'h03, {6'h00, pt, sto});
        ir_tx = 1'b0;
        @(posedge mclk_i);
        #1 rst_i = 1'b1;
        @(posedge mclk_i);
        #1 rst_i = 1'b0;
        rchk(8'h0a, 8'h00);
        rchk(8'h0c, 8'h02);
        $display("ir route and re-reset done");
    endtask
    task automatic t_decode();
        logic [15:0] al [5] = '{16'h0a50, 16'h0a57, 16'h0a5f, 16'h1a50, 16'h0a60};
        logic hit;
        host_bus_model_inst.wr_reg(8'h08, 8'h50);
        for (int m = 0; m < 4; m++) begin
            host_bus_model_inst.wr_reg(8'h09, {2'(m), 6'h0a});
            foreach (al[k]) begin
                @(posedge mclk_i);
                #1 io_addr = al[k];
                @(posedge mclk_i);
                #1 hit = al[k][15:4] == 12'h0a5 && (m == 3 || (m == 2 && !al[k][3])
                    || (m == 1 && al[k][3:0] == 4'h0));
                chk("select", {7'h00, !hit}, {7'h00, sel_n});
            end
        end
        $display("decoder modes done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        t_reset();
        t_write();
        t_refuse();
        t_route();
        t_decode();
        end_sim();
    end
    initial begin
        #20000 n_fail++;
        end_sim();
    end
endmodule // config_regs_addr_decode_uart_ir_tb
`default_nettype wire
